// [rtl/bbo_pkg.sv]
// package: constants and types for the branch and bit operation unit
package bbo_pkg;
    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [8:0] ADDR_INSTR = 9'h000;
    localparam logic [8:0] ADDR_PC = 9'h004;
    localparam logic [8:0] ADDR_STATUS = 9'h008;
    localparam logic [8:0] ADDR_CYCLES = 9'h00c;
    localparam logic [1:0] AREA_GPR = 2'h2;
    localparam logic [1:0] AREA_IO = 2'h3;
    // ------------------------------------------------------------
    // instruction word fields
    // ------------------------------------------------------------
    localparam int F_OP_LSB = 11;
    localparam int F_K_LSB = 4;
    localparam int F_A_LSB = 5;
    localparam int F_TWO = 16;
    // ------------------------------------------------------------
    // status register bit positions
    // ------------------------------------------------------------
    localparam int SB_C = 0;
    localparam int SB_Z = 1;
    localparam int SB_N = 2;
    localparam int SB_V = 3;
    localparam int SB_S = 4;
    localparam int SB_H = 5;
    localparam int SB_T = 6;
    localparam int SB_I = 7;
    // ------------------------------------------------------------
    // reset values and cycle counts
    // ------------------------------------------------------------
    localparam logic [15:0] PC_RST = 16'h0000;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_TWO = 2'h2;
    localparam logic [1:0] CYC_THREE = 2'h3;
    // ------------------------------------------------------------
    // operations and sequencer states
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        OP_SKIP_CLR, OP_SKIP_SET, OP_BR_SET, OP_BR_CLR, OP_BR_CC,
        OP_BR_SH, OP_BR_GE, OP_BR_LT, OP_BR_HS, OP_BR_HC, OP_BR_TS,
        OP_BR_IE, OP_BR_ID, OP_IO_SET, OP_IO_CLR, OP_SHIFT_LL,
        OP_SHIFT_RL, OP_ROT_LC, OP_ROT_RC, OP_SHIFT_RA, OP_SWAP,
        OP_FORCE_ONE, OP_FORCE_ZERO, OP_BIT_TO_TF, OP_TF_TO_BIT,
        OP_SEC, OP_CLC, OP_SEN, OP_CLN, OP_SEZ, OP_CLZ
    } bbo_op_t;
    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_BUSY = 2'b01,
        S_DONE = 2'b11
    } bbo_state_t;
endpackage : bbo_pkg

// [rtl/bbo_unit.sv]
// module: branch, skip and bit operation execution unit
// Behaviour
// - skip-if-cleared skips next when I/O bit zero; pc +2/+3, 1/2/3 cycles
// - skip-if-set skips next when I/O bit one, same advance and cycles
// - branch_on_flag_set jumps to pc+k+1 when status bit set; 1/2 cycles
// - branch_on_flag_clear jumps the same way when status bit clear
// - branch_carry_zero jumps only when carry is zero, else falls through
// - branch_unsigned_ge jumps when carry is zero, same target
// - branch_signed_ge jumps when negative xor overflow is zero
// - branch_signed_lt jumps when negative xor overflow is one
// - half-carry branches jump when that flag is one, or zero
// - branch_transfer_flag_one jumps to pc+k+1 when transfer flag set
// - branch_irq_on jumps when interrupt enable is one, flags untouched
// - branch_irq_off jumps when interrupt enable is zero, flags untouched
// - io_bit_set_op writes one to I/O bit, nothing else, two cycles
// - io_bit_clear_op writes zero to I/O bit, no flags, two cycles
// - rotate_left_carry: carry into bit0, bit7 to carry, Z C N V
// - rotate_right_carry: carry into bit7, bit0 to carry, Z C N V
// - bit_to_transfer_flag copies register bit into transfer flag
// - transfer_flag_to_bit copies transfer flag into register bit
//
// Chosen here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/100ps
module bbo_unit
    import bbo_pkg::*;
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    // avalon-mm slave
    input wire logic [8:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // core state
    output logic [15:0] o_pc,
    output logic [7:0] o_status
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0] gpr [32];
    logic [7:0] io_mem [32];
    logic [15:0] pc;
    logic [7:0] status_register;
    logic [16:0] ins;
    logic [1:0] cnt;
    logic [1:0] last_cyc;
    logic rd_ack;
    bbo_state_t st;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function automatic logic in_area(input logic [8:0] ad,
                                     input logic [1:0] area);
        in_area = (ad[8:7] == area) && (ad[1:0] == 2'h0);
    endfunction : in_area

    wire sel_instr = (i_avs_address == ADDR_INSTR);
    wire wr_ok = i_avs_write && i_avs_byteenable[0];
    wire go = wr_ok && sel_instr && (st == S_IDLE);
    wire [4:0] bus_idx = i_avs_address[6:2];
    wire bus_gpr_wr = wr_ok && in_area(i_avs_address, AREA_GPR);
    wire bus_io_wr = wr_ok && in_area(i_avs_address, AREA_IO);
    wire bus_pc_wr = wr_ok && (i_avs_address == ADDR_PC);
    wire bus_sr_wr = wr_ok && (i_avs_address == ADDR_STATUS);

    // ------------------------------------------------------------
    // instruction fields
    // ------------------------------------------------------------
    wire bbo_op_t op = bbo_op_t'(ins[15:F_OP_LSB]);
    wire [6:0] k = ins[F_K_LSB+6:F_K_LSB];
    wire [4:0] fa = ins[F_A_LSB+4:F_A_LSB];
    wire [2:0] fb = ins[2:0];
    wire two = ins[F_TWO];
    wire [7:0] rv = gpr[fa];
    wire [7:0] iv = io_mem[fa];
    wire iob = iv[fb];
    wire sbit = status_register[fb];
    wire f_c = status_register[SB_C];
    wire f_nv = status_register[SB_N] ^ status_register[SB_V];

    // ------------------------------------------------------------
    // condition and cycle count
    // ------------------------------------------------------------
    logic take;
    logic is_skip;
    logic is_br;
    always_comb
    begin
        take = 1'b0;
        is_skip = 1'b0;
        is_br = 1'b1;
        case (op)
            OP_SKIP_CLR:
            begin
                take = !iob;
                is_skip = 1'b1;
                is_br = 1'b0;
            end
            OP_SKIP_SET:
            begin
                take = iob;
                is_skip = 1'b1;
                is_br = 1'b0;
            end
            OP_BR_SET: take = sbit;
            OP_BR_CLR: take = !sbit;
            OP_BR_CC: take = !f_c;
            OP_BR_SH: take = !f_c;
            OP_BR_GE: take = !f_nv;
            OP_BR_LT: take = f_nv;
            OP_BR_HS: take = status_register[SB_H];
            OP_BR_HC: take = !status_register[SB_H];
            OP_BR_TS: take = status_register[SB_T];
            OP_BR_IE: take = status_register[SB_I];
            OP_BR_ID: take = !status_register[SB_I];
            default: is_br = 1'b0;
        endcase
    end

    wire is_io = (op == OP_IO_SET) || (op == OP_IO_CLR);
    wire [1:0] skip_cyc = two ? CYC_THREE : CYC_TWO;
    wire [1:0] need = (is_skip && take) ? skip_cyc :
                      (is_br && take) ? CYC_TWO :
                      is_io ? CYC_TWO : CYC_ONE;
    wire [15:0] k_ext = {{9{k[6]}}, k};
    wire [15:0] pc_skip = pc + 16'h0002 + {15'h0000, two};
    wire [15:0] next_pc = (is_skip && take) ? pc_skip :
                          (is_br && take) ? pc + k_ext + 16'h0001 :
                          pc + 16'h0001;

    // ------------------------------------------------------------
    // register and flag results
    // ------------------------------------------------------------
    logic [7:0] res;
    logic res_c;
    logic shift_op;
    logic gpr_we;
    always_comb
    begin
        res = rv;
        res_c = f_c;
        shift_op = 1'b1;
        gpr_we = 1'b1;
        case (op)
            OP_SHIFT_LL: {res_c, res} = {rv, 1'b0};
            OP_SHIFT_RL: {res, res_c} = {1'b0, rv};
            OP_SHIFT_RA: {res, res_c} = {rv[7], rv};
            OP_ROT_LC: {res_c, res} = {rv, f_c};
            OP_ROT_RC: {res, res_c} = {f_c, rv};
            OP_SWAP:
            begin
                res = {rv[3:0], rv[7:4]};
                shift_op = 1'b0;
            end
            OP_TF_TO_BIT:
            begin
                res[fb] = status_register[SB_T];
                shift_op = 1'b0;
            end
            default:
            begin
                shift_op = 1'b0;
                gpr_we = 1'b0;
            end
        endcase
    end

    logic [7:0] next_status;
    always_comb
    begin
        next_status = status_register;
        case (op)
            OP_FORCE_ONE: next_status[fb] = 1'b1;
            OP_FORCE_ZERO: next_status[fb] = 1'b0;
            OP_SEC: next_status[SB_C] = 1'b1;
            OP_CLC: next_status[SB_C] = 1'b0;
            OP_SEN: next_status[SB_N] = 1'b1;
            OP_CLN: next_status[SB_N] = 1'b0;
            OP_SEZ: next_status[SB_Z] = 1'b1;
            OP_CLZ: next_status[SB_Z] = 1'b0;
            OP_BIT_TO_TF: next_status[SB_T] = rv[fb];
            default:
            begin
                if (shift_op)
                begin
                    next_status[SB_C] = res_c;
                    next_status[SB_Z] = (res == 8'h00);
                    next_status[SB_N] = res[7];
                    next_status[SB_V] = res[7] ^ res_c;
                end
            end
        endcase
    end

    wire [7:0] io_res = (op == OP_IO_SET) ? (iv | (8'h01 << fb)) :
                        (iv & ~(8'h01 << fb));
    wire fin = (st == S_DONE);

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            st <= S_IDLE;
            cnt <= 2'h0;
            ins <= 17'h00000;
            last_cyc <= 2'h0;
        end
        else
        begin
            case (st)
                S_IDLE:
                begin
                    if (go)
                    begin
                        ins <= i_avs_writedata[16:0];
                        cnt <= 2'h0;
                        st <= S_BUSY;
                    end
                end
                S_BUSY:
                begin
                    cnt <= cnt + 2'h1;
                    if (cnt + 2'h1 == need)
                    begin
                        last_cyc <= need;
                        st <= S_DONE;
                    end
                end
                S_DONE: st <= S_IDLE;
                default: st <= S_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // program counter, status, register file, i/o space
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            pc <= PC_RST;
            status_register <= STATUS_RST;
        end
        else if (fin)
        begin
            pc <= next_pc;
            status_register <= next_status;
        end
        else
        begin
            if (bus_pc_wr)
                pc <= i_avs_writedata[15:0];
            if (bus_sr_wr)
                status_register <= i_avs_writedata[7:0];
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            for (int i = 0; i < 32; i++)
            begin
                gpr[i] <= 8'h00;
                io_mem[i] <= 8'h00;
            end
        end
        else if (fin)
        begin
            if (gpr_we)
                gpr[fa] <= res;
            if (is_io)
                io_mem[fa] <= io_res;
        end
        else
        begin
            if (bus_gpr_wr)
                gpr[bus_idx] <= i_avs_writedata[7:0];
            if (bus_io_wr)
                io_mem[bus_idx] <= i_avs_writedata[7:0];
        end
    end

    // ------------------------------------------------------------
    // bus answer
    // ------------------------------------------------------------
    wire [31:0] rd_mux =
        (i_avs_address == ADDR_INSTR) ? {15'h0000, ins} :
        (i_avs_address == ADDR_PC) ? {16'h0000, pc} :
        (i_avs_address == ADDR_STATUS) ? {24'h000000, status_register} :
        (i_avs_address == ADDR_CYCLES) ? {30'h00000000, last_cyc} :
        in_area(i_avs_address, AREA_GPR) ? {24'h000000, gpr[bus_idx]} :
        in_area(i_avs_address, AREA_IO) ? {24'h000000, io_mem[bus_idx]} :
        32'h00000000;

    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            rd_ack <= 1'b0;
            o_avs_readdata <= 32'h00000000;
        end
        else
        begin
            rd_ack <= i_avs_read && !rd_ack;
            if (i_avs_read && !rd_ack)
                o_avs_readdata <= rd_mux;
        end
    end

    assign o_avs_waitrequest = (i_avs_read && !rd_ack) ||
                               (wr_ok && sel_instr && !fin);
    assign o_pc = pc;
    assign o_status = status_register;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_resetn);

    sequence s_fin(bbo_op_t o);
        fin && (op == o);
    endsequence

    property p_skip_clr;
        s_fin(OP_SKIP_CLR) and (take && !two)
            |=> pc == $past(pc) + 16'h0002;
    endproperty
    a_skip_clr: assert property (p_skip_clr)
        else $error("skip on cleared bit wrong pc");

    property p_skip_set;
        s_fin(OP_SKIP_SET) and (iob && two)
            |=> pc == $past(pc) + 16'h0003;
    endproperty
    a_skip_set: assert property (p_skip_set)
        else $error("skip on set bit wrong pc");

    property p_br_cycles;
        (st == S_BUSY && cnt == 2'h0 && is_br && take)
            |=> (st == S_BUSY) ##1 (st == S_DONE);
    endproperty
    a_br_cycles: assert property (p_br_cycles)
        else $error("taken branch not two cycles");

    property p_br_clr;
        s_fin(OP_BR_CLR) and sbit |=> pc == $past(pc) + 16'h0001;
    endproperty
    a_br_clr: assert property (p_br_clr)
        else $error("branch on clear flag taken wrongly");

    property p_br_cc;
        s_fin(OP_BR_CC) and !f_c
            |=> pc == $past(pc) + $past(k_ext) + 16'h0001;
    endproperty
    a_br_cc: assert property (p_br_cc)
        else $error("carry-zero branch target wrong");

    property p_br_ge;
        s_fin(OP_BR_GE) and !f_nv
            |=> pc == $past(pc) + $past(k_ext) + 16'h0001;
    endproperty
    a_br_ge: assert property (p_br_ge)
        else $error("signed ge condition wrong");

    property p_br_lt;
        s_fin(OP_BR_LT) and f_nv |=> pc != $past(pc) + 16'h0001 ||
            $past(k) == 7'h00;
    endproperty
    a_br_lt: assert property (p_br_lt)
        else $error("signed lt branch not taken");

    property p_br_flags;
        fin && is_br |=> status_register == $past(status_register);
    endproperty
    a_br_flags: assert property (p_br_flags)
        else $error("branch altered flags");

    property p_io_set;
        s_fin(OP_IO_SET) |=> io_mem[$past(fa)][$past(fb)] &&
            status_register == $past(status_register);
    endproperty
    a_io_set: assert property (p_io_set)
        else $error("io bit set failed");

    property p_rol;
        s_fin(OP_ROT_LC) |=> gpr[$past(fa)][0] == $past(f_c) &&
            status_register[SB_C] == $past(rv[7]);
    endproperty
    a_rol: assert property (p_rol)
        else $error("rotate left through carry wrong");

    property p_bst;
        s_fin(OP_BIT_TO_TF) |=> status_register[SB_T] == $past(rv[fb]);
    endproperty
    a_bst: assert property (p_bst)
        else $error("transfer flag not loaded");

    property p_swap;
        s_fin(OP_SWAP) |=> status_register == $past(status_register) &&
            gpr[$past(fa)] == {$past(rv[3:0]), $past(rv[7:4])};
    endproperty
    a_swap: assert property (p_swap)
        else $error("nibble swap wrong");
endmodule : bbo_unit

// [test/bbo_unit_tb.sv]
// testbench: self-checking bench for the branch and bit operation unit
`timescale 1ns/100ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
    miscompares++; $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module bbo_unit_tb
    import bbo_pkg::*;
;
    // ------------------------------------------------------------
    // signals and tables
    // ------------------------------------------------------------
    localparam logic [15:0] PC0 = 16'h0200;
    logic i_ref_clk;
    logic i_resetn;
    logic [8:0] i_avs_address;
    logic i_avs_read;
    logic i_avs_write;
    logic [3:0] i_avs_byteenable;
    logic [31:0] i_avs_writedata;
    logic [31:0] o_avs_readdata;
    logic o_avs_waitrequest;
    logic [15:0] o_pc;
    logic [7:0] o_status;
    int miscompares = 0;
    int comparisons = 0;
    // status that takes / does not take each branch, ops 2..12
    logic [7:0] tk [11] = '{8'h20, 8'hfd, 8'hfe, 8'hfe, 8'h0c, 8'h08,
                            8'h20, 8'hdf, 8'h40, 8'h80, 8'h7f};
    logic [7:0] nt [11] = '{8'h00, 8'h02, 8'h01, 8'h01, 8'h04, 8'h0c,
                            8'hdf, 8'h20, 8'hbf, 8'h7f, 8'h80};

    bbo_unit bbo_unit_i (
        .i_ref_clk(i_ref_clk),
        .i_resetn(i_resetn),
        .i_avs_address(i_avs_address),
        .i_avs_read(i_avs_read),
        .i_avs_write(i_avs_write),
        .i_avs_byteenable(i_avs_byteenable),
        .i_avs_writedata(i_avs_writedata),
        .o_avs_readdata(o_avs_readdata),
        .o_avs_waitrequest(o_avs_waitrequest),
        .o_pc(o_pc),
        .o_status(o_status)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic wrap_up();
        if (miscompares == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : wrap_up

    function automatic logic [8:0] ga(input int i);
        return 9'h100 + 9'(i * 4);
    endfunction : ga

    function automatic logic [31:0] enc(input logic two, input bbo_op_t op,
        input logic [6:0] k, input logic [2:0] b);
        return {15'h0, two, op, k, 1'b0, b};
    endfunction : enc

    function automatic logic [15:0] shx(input bbo_op_t op,
        input logic [7:0] v, input logic [7:0] s);
        logic [7:0] r;
        logic [7:0] ns;
        logic c;
        ns = s;
        case (op)
            OP_SHIFT_LL: {c, r} = {v, 1'b0};
            OP_SHIFT_RL: {r, c} = {1'b0, v};
            OP_ROT_LC: {c, r} = {v, s[SB_C]};
            OP_ROT_RC: {r, c} = {s[SB_C], v};
            OP_SHIFT_RA: {r, c} = {v[7], v};
            default: return {s, v[3:0], v[7:4]};
        endcase
        ns[SB_C] = c;
        ns[SB_Z] = (r == 8'h00);
        ns[SB_N] = r[7];
        ns[SB_V] = r[7] ^ c;
        return {ns, r};
    endfunction : shx

    task automatic bus(input logic wr, input logic [8:0] a,
        input logic [31:0] d, input logic [3:0] be,
        output logic [31:0] q, output int nw);
        logic w;
        nw = 0;
        @(posedge i_ref_clk);
        i_avs_write <= wr;
        i_avs_read <= !wr;
        i_avs_address <= a;
        i_avs_writedata <= d;
        i_avs_byteenable <= be;
        do
        begin
            @(negedge i_ref_clk);
            w = o_avs_waitrequest;
            q = o_avs_readdata;
            @(posedge i_ref_clk);
            if (w !== 1'b0)
                nw++;
        end while (w !== 1'b0 && nw < 20);
        if (nw >= 20)
        begin
            miscompares++;
            wrap_up();
        end
        i_avs_write <= 1'b0;
        i_avs_read <= 1'b0;
    endtask : bus

    task automatic wr(input logic [8:0] a, input logic [31:0] d,
        input logic [3:0] be = 4'hf);
        logic [31:0] q;
        int nw;
        bus(1'b1, a, d, be, q, nw);
    endtask : wr

    task automatic chk_rd(input string nm, input logic [8:0] a,
        input logic [31:0] e);
        logic [31:0] q;
        int nw;
        bus(1'b0, a, 32'h0, 4'hf, q, nw);
        `CHK(nm, e, q)
    endtask : chk_rd

    task automatic exec(input logic [31:0] ins, input logic [7:0] st,
        input logic [15:0] epc, input logic [7:0] est, input logic [1:0] cy);
        logic [31:0] q;
        int nw;
        wr(ADDR_PC, {16'h0, PC0});
        wr(ADDR_STATUS, {24'h0, st});
        bus(1'b1, ADDR_INSTR, ins, 4'hf, q, nw);
        @(negedge i_ref_clk);
        `CHK("pc", epc, o_pc)
        `CHK("status", est, o_status)
        `CHK("wait states", int'(cy) + 1, nw)
        chk_rd("cycles", ADDR_CYCLES, {30'h0, cy});
    endtask : exec

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset(input logic again);
        if (again)
        begin
            @(posedge i_ref_clk);
            i_resetn <= 1'b0;
            repeat (2) @(posedge i_ref_clk);
            i_resetn <= 1'b1;
        end
        @(negedge i_ref_clk);
        `CHK("reset pc", PC_RST, o_pc)
        `CHK("reset status", STATUS_RST, o_status)
        chk_rd("reset gpr", ga(12), 32'h0);
        wr(9'h040, 32'hff);
        chk_rd("unmapped", 9'h040, 32'h0);
        wr(ga(0), 32'h33, 4'he);
        chk_rd("masked write", ga(0), 32'h0);
        wr(ADDR_INSTR, 32'h1ffff, 4'he);
        chk_rd("masked instr", ADDR_INSTR, 32'h0);
    endtask : t_reset

    task automatic sk(input logic two, input bbo_op_t op, input logic [2:0] b,
        input logic [15:0] off, input logic [1:0] cy);
        exec(enc(two, op, 7'h06, b), 8'h5a, PC0 + off, 8'h5a, cy);
    endtask : sk

    task automatic br_pair(input int i);
        logic [6:0] k;
        logic [31:0] ins;
        k = i[0] ? 7'h40 : 7'h3f;
        ins = enc(1'b0, bbo_op_t'(i + 2), k, (i == 0) ? 3'd5 : 3'd1);
        exec(ins, tk[i], PC0 + {{9{k[6]}}, k} + 16'h1, tk[i], CYC_TWO);
        exec(ins, nt[i], PC0 + 16'h1, nt[i], CYC_ONE);
    endtask : br_pair

    task automatic io_op(input bbo_op_t op, input logic [2:0] b,
        input logic [7:0] st, input logic [7:0] e);
        exec(enc(1'b0, op, 7'h0a, b), st, PC0 + 16'h1, st, CYC_TWO);
        chk_rd("io byte", 9'h194, {24'h0, e});
    endtask : io_op

    task automatic sh_one(input bbo_op_t op, input logic [7:0] v,
        input logic [7:0] s);
        logic [15:0] e;
        e = shx(op, v, s);
        wr(ga(9), {24'h0, v});
        exec(enc(1'b0, op, 7'h12, 3'd0), s, PC0 + 16'h1, e[15:8], CYC_ONE);
        chk_rd("shift result", ga(9), {24'h0, e[7:0]});
    endtask : sh_one

    task automatic fl_one(input bbo_op_t op, input logic [2:0] b,
        input logic [7:0] st, input logic [7:0] e);
        exec(enc(1'b0, op, 7'h18, b), st, PC0 + 16'h1, e, CYC_ONE);
    endtask : fl_one

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end

    initial
    begin
        repeat (50000) @(posedge i_ref_clk);
        miscompares++;
        wrap_up();
    end

    initial
    begin
        i_resetn = 1'b0;
        i_avs_address = 9'h0;
        i_avs_read = 1'b0;
        i_avs_write = 1'b0;
        i_avs_byteenable = 4'h0;
        i_avs_writedata = 32'h0;
        repeat (6) @(posedge i_ref_clk);
        i_resetn <= 1'b1;
        t_reset(1'b0);
        wr(9'h18c, 32'h04);
        sk(1'b0, OP_SKIP_CLR, 3'd2, 16'h1, CYC_ONE);
        sk(1'b1, OP_SKIP_CLR, 3'd3, 16'h3, CYC_THREE);
        sk(1'b0, OP_SKIP_CLR, 3'd0, 16'h2, CYC_TWO);
        sk(1'b0, OP_SKIP_SET, 3'd2, 16'h2, CYC_TWO);
        sk(1'b1, OP_SKIP_SET, 3'd2, 16'h3, CYC_THREE);
        sk(1'b1, OP_SKIP_SET, 3'd0, 16'h1, CYC_ONE);
        for (int i = 0; i < 6; i++)
            br_pair(i);
        for (int i = 6; i < 11; i++)
            br_pair(i);
        wr(9'h194, 32'h5a);
        io_op(OP_IO_SET, 3'd0, 8'hff, 8'h5b);
        io_op(OP_IO_SET, 3'd1, 8'h00, 8'h5b);
        io_op(OP_IO_CLR, 3'd6, 8'h00, 8'h1b);
        io_op(OP_IO_CLR, 3'd7, 8'hff, 8'h1b);
        chk_rd("io neighbour", 9'h190, 32'h0);
        wr(ADDR_CYCLES, 32'h0);
        chk_rd("cycles ro", ADDR_CYCLES, {30'h0, CYC_TWO});
        sh_one(OP_ROT_LC, 8'h81, 8'hf5);
        sh_one(OP_ROT_LC, 8'h80, 8'h0a);
        sh_one(OP_ROT_RC, 8'h81, 8'hf5);
        sh_one(OP_ROT_RC, 8'h01, 8'h0a);
        sh_one(OP_SHIFT_LL, 8'h81, 8'h0a);
        sh_one(OP_SHIFT_RL, 8'h81, 8'hf5);
        sh_one(OP_SHIFT_RA, 8'h81, 8'h0a);
        sh_one(OP_SHIFT_RA, 8'h7e, 8'hf5);
        sh_one(OP_SWAP, 8'h3c, 8'hff);
        wr(ga(12), 32'h10);
        fl_one(OP_BIT_TO_TF, 3'd4, 8'h00, 8'h40);
        fl_one(OP_BIT_TO_TF, 3'd3, 8'hff, 8'hbf);
        fl_one(OP_TF_TO_BIT, 3'd7, 8'h40, 8'h40);
        chk_rd("bit load", ga(12), 32'h90);
        fl_one(OP_TF_TO_BIT, 3'd4, 8'hbf, 8'hbf);
        chk_rd("bit load", ga(12), 32'h80);
        for (int s = 0; s < 8; s++)
            fl_one(OP_FORCE_ONE, 3'(s), 8'h00, 8'h01 << s);
        for (int s = 0; s < 8; s++)
            fl_one(OP_FORCE_ZERO, 3'(s), 8'hff, ~(8'h01 << s));
        fl_one(OP_SEC, 3'd0, 8'h00, 8'h01);
        fl_one(OP_CLC, 3'd0, 8'hff, 8'hfe);
        fl_one(OP_SEN, 3'd0, 8'h00, 8'h04);
        fl_one(OP_CLN, 3'd0, 8'hff, 8'hfb);
        fl_one(OP_SEZ, 3'd0, 8'h00, 8'h02);
        fl_one(OP_CLZ, 3'd0, 8'hff, 8'hfd);
        exec({15'h0, 1'b0, 5'h1f, 11'h0}, 8'h5a, PC0 + 16'h1, 8'h5a, CYC_ONE);
        t_reset(1'b1);
        wrap_up();
    end
endmodule : bbo_unit_tb
